/* hw/jil_cksum.v */
// Purpose: checksum over the configuration fields of one lane
// Assumes: octets arrive one per strobe with their index, same clock
// Notes:   only defined field bits are summed, modulo 256
`timescale 1ns/1ps
`default_nettype none
`include "jil_map.vh"

module jil_cksum (
    // clock and reset
    input  wire                  clk,
    input  wire                  rst,
    // octet stream
    input  wire                  start,
    input  wire                  oct_vld,
    input  wire [`JIL_IDX_W-1:0] oct_idx,
    input  wire [7:0]            oct_data,
    // running sum
    output reg  [7:0]            sum
);

reg  [7:0] fld_sum;

// ==========================================================================
// field sum of one octet
always @* begin
    case (oct_idx)
        4'h0: fld_sum = oct_data;
        4'h1: fld_sum = {4'h0, oct_data[7:4]} + {4'h0, oct_data[3:0]};
        4'h2: fld_sum = {7'h00, oct_data[6]} + {7'h00, oct_data[5]} + {3'h0, oct_data[4:0]};
        4'h3: fld_sum = {7'h00, oct_data[7]} + {3'h0, oct_data[4:0]};
        4'h4: fld_sum = oct_data;
        4'h5: fld_sum = {3'h0, oct_data[4:0]};
        4'h6: fld_sum = oct_data;
        4'h7: fld_sum = {6'h00, oct_data[7:6]} + {3'h0, oct_data[4:0]};
        4'h8: fld_sum = {5'h00, oct_data[7:5]} + {3'h0, oct_data[4:0]};
        4'h9: fld_sum = {5'h00, oct_data[7:5]} + {3'h0, oct_data[4:0]};
        4'ha: fld_sum = {7'h00, oct_data[7]} + {3'h0, oct_data[4:0]};
        4'hb: fld_sum = oct_data;
        4'hc: fld_sum = oct_data;
        default: fld_sum = 8'h00;
    endcase
end

// ==========================================================================
// accumulate modulo 256
always @(posedge clk) begin
    if (rst || start) begin
        sum <= 8'h00;
    end else if (oct_vld && oct_idx <= `JIL_IDX_LAST_FIELD) begin
        sum <= sum + fld_sum;
    end
end

endmodule
`default_nettype wire

/* hw/jil_fld_reg.v */
// Purpose: one software-writable field with a reset value
// Assumes: synchronous active-high reset, write strobe on the same clock
// Notes:   output straight from the flip-flops
`timescale 1ns/1ps
`default_nettype none

module jil_fld_reg #(
    parameter       W   = 8,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst,
    // write side
    input  wire         we,
    input  wire [W-1:0] wdata,
    // field value
    output reg  [W-1:0] q
);

// ==========================================================================
// storage
always @(posedge clk) begin
    if (rst) begin
        q <= RST;
    end else if (we) begin
        q <= wdata;
    end
end

endmodule
`default_nettype wire

/* hw/jil_regs.v */
// Purpose: lane alignment parameter register bank, lane 7 capture and lane 0
//          expected link parameters
// Assumes: byte-wide configuration port on clk; alignment octets from the
//          receive lane logic on the same clock
// Notes:   read data registered, one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "jil_map.vh"

module jil_regs (
    // clock and reset
    input  wire                   clk,
    input  wire                   rst,
    // configuration port
    input  wire [`JIL_ADDR_W-1:0] cfg_addr,
    input  wire                   cfg_wr,
    input  wire                   cfg_rd,
    input  wire [7:0]             cfg_wdata,
    output reg  [7:0]             cfg_rdata,
    output reg                    cfg_rvalid,
    // lane 7 alignment sequence octets
    input  wire                   l7_ilas_start,
    input  wire                   l7_oct_vld,
    input  wire [`JIL_IDX_W-1:0]  l7_oct_idx,
    input  wire [7:0]             l7_oct_data,
    // link core parameters
    output reg  [7:0]             link_device_identifier,
    output reg  [7:0]             link_bank_identifier,
    output reg  [4:0]             lane_zero_identifier,
    output reg                    multiframe_adjust_direction,
    output reg                    phase_adjust_request,
    output reg                    descramble_enable,
    output reg  [4:0]             frames_per_multiframe
);

// ==========================================================================
// address decode
wire we_devid;
wire we_bankid;
wire we_lane0;
wire we_dscr;
wire we_k;

assign we_devid  = cfg_wr && (cfg_addr == `JIL_OFS_DEV_IDENT);
assign we_bankid = cfg_wr && (cfg_addr == `JIL_OFS_BANK_IDENT);
assign we_lane0  = cfg_wr && (cfg_addr == `JIL_OFS_LANE0_ADJ);
assign we_dscr   = cfg_wr && (cfg_addr == `JIL_OFS_DSCR_LANES);
assign we_k      = cfg_wr && (cfg_addr == `JIL_OFS_FRAMES_MF);

// ==========================================================================
// writable fields
wire [7:0] devid_q;
wire [7:0] bankid_q;
wire [6:0] lane0_q;
wire [0:0] dscr_q;
wire [4:0] k_q;

// software keeps this equal to the received identifier readback
jil_fld_reg #(
    .W   (8),
    .RST (`JIL_RST_DEV_IDENT)
) u_devid (
    .clk   (clk),
    .rst   (rst),
    .we    (we_devid),
    .wdata (cfg_wdata),
    .q     (devid_q)
);

// bank identifier, full byte
jil_fld_reg #(
    .W   (8),
    .RST (`JIL_RST_BANK_IDENT)
) u_bankid (
    .clk   (clk),
    .rst   (rst),
    .we    (we_bankid),
    .wdata (cfg_wdata),
    .q     (bankid_q)
);

// bit 7 reserved and dropped on write
jil_fld_reg #(
    .W   (7),
    .RST (`JIL_RST_LANE0_ADJ)
) u_lane0 (
    .clk   (clk),
    .rst   (rst),
    .we    (we_lane0),
    .wdata (cfg_wdata[6:0]),
    .q     (lane0_q)
);

// only the enable bit is stored; lane count is fixed
jil_fld_reg #(
    .W   (1),
    .RST (`JIL_RST_DSCR)
) u_dscr (
    .clk   (clk),
    .rst   (rst),
    .we    (we_dscr),
    .wdata (cfg_wdata[`JIL_DSCR_BIT]),
    .q     (dscr_q)
);

// upper three bits reserved
jil_fld_reg #(
    .W   (5),
    .RST (`JIL_RST_FRAMES_MF)
) u_k (
    .clk   (clk),
    .rst   (rst),
    .we    (we_k),
    .wdata (cfg_wdata[`JIL_K_MSB:0]),
    .q     (k_q)
);

// ==========================================================================
// parameter outputs to the link core
always @(posedge clk) begin
    if (rst) begin
        link_device_identifier      <= `JIL_RST_DEV_IDENT;
        link_bank_identifier        <= `JIL_RST_BANK_IDENT;
        lane_zero_identifier        <= 5'h00;
        multiframe_adjust_direction <= 1'b0;
        phase_adjust_request        <= 1'b0;
        descramble_enable           <= `JIL_RST_DSCR;
        frames_per_multiframe       <= `JIL_RST_FRAMES_MF;
    end else begin
        link_device_identifier      <= devid_q;
        link_bank_identifier        <= bankid_q;
        lane_zero_identifier        <= lane0_q[`JIL_LID_MSB:0];
        multiframe_adjust_direction <= lane0_q[`JIL_ADJ_DIR_BIT];
        phase_adjust_request        <= lane0_q[`JIL_PH_ADJ_BIT];
        descramble_enable           <= dscr_q[0];
        frames_per_multiframe       <= k_q;
    end
end

// ==========================================================================
// lane 7 capture
wire [7:0] l7_sum;
reg  [4:0] l7_lid_r;
reg  [7:0] l7_rx_cksum_r;
reg  [7:0] l7_cmp_cksum_r;

jil_cksum u_l7_sum (
    .clk      (clk),
    .rst      (rst),
    .start    (l7_ilas_start),
    .oct_vld  (l7_oct_vld),
    .oct_idx  (l7_oct_idx),
    .oct_data (l7_oct_data),
    .sum      (l7_sum)
);

always @(posedge clk) begin
    if (rst) begin
        l7_lid_r       <= 5'h00;
        l7_rx_cksum_r  <= 8'h00;
        l7_cmp_cksum_r <= 8'h00;
    end else if (l7_oct_vld) begin
        if (l7_oct_idx == `JIL_IDX_LANE_ID) begin
            l7_lid_r <= l7_oct_data[`JIL_LID_MSB:0];
        end
        if (l7_oct_idx == `JIL_IDX_CHECKSUM) begin
            l7_rx_cksum_r  <= l7_oct_data;
            l7_cmp_cksum_r <= l7_sum;
        end
    end
end

// ==========================================================================
// read mux
reg [7:0] rd_mux;

always @* begin
    case (cfg_addr)
        `JIL_OFS_L7_LANE_ID:   rd_mux = {3'h0, l7_lid_r};
        `JIL_OFS_L7_RX_CKSUM:  rd_mux = l7_rx_cksum_r;
        `JIL_OFS_L7_CMP_CKSUM: rd_mux = l7_cmp_cksum_r;
        `JIL_OFS_DEV_IDENT:    rd_mux = devid_q;
        `JIL_OFS_BANK_IDENT:   rd_mux = bankid_q;
        `JIL_OFS_LANE0_ADJ:    rd_mux = {1'b0, lane0_q};
        `JIL_OFS_DSCR_LANES:   rd_mux = {dscr_q, 2'h0, `JIL_RST_LANES_M1};
        `JIL_OFS_OCTETS:       rd_mux = `JIL_RST_OCTETS_M1;
        `JIL_OFS_FRAMES_MF:    rd_mux = {3'h0, k_q};
        `JIL_OFS_CONV_COUNT:   rd_mux = `JIL_RST_CONV_M1;
        `JIL_OFS_CS_RES:       rd_mux = {`JIL_RST_CS, 1'b0, `JIL_RST_RES_M1};
        default:               rd_mux = 8'h00;
    endcase
end

// ==========================================================================
// registered read answer
always @(posedge clk) begin
    if (rst) begin
        cfg_rdata  <= 8'h00;
        cfg_rvalid <= 1'b0;
    end else begin
        cfg_rvalid <= cfg_rd;
        if (cfg_rd) begin
            cfg_rdata <= rd_mux;
        end
    end
end

endmodule
`default_nettype wire

/* shared/jil_map.vh */
// Purpose: register map, field positions, reset values and constants for the
//          lane alignment parameter register bank
// Assumes: byte-wide configuration port, 12-bit register address
// Notes:   definitions only
`ifndef JIL_MAP_VH
`define JIL_MAP_VH

// ==========================================================================
// register offsets
`define JIL_ADDR_W              12
`define JIL_OFS_L7_LANE_ID      12'h442
`define JIL_OFS_L7_RX_CKSUM     12'h445
`define JIL_OFS_L7_CMP_CKSUM    12'h446
`define JIL_OFS_DEV_IDENT       12'h450
`define JIL_OFS_BANK_IDENT      12'h451
`define JIL_OFS_LANE0_ADJ       12'h452
`define JIL_OFS_DSCR_LANES      12'h453
`define JIL_OFS_OCTETS          12'h454
`define JIL_OFS_FRAMES_MF       12'h455
`define JIL_OFS_CONV_COUNT      12'h456
`define JIL_OFS_CS_RES          12'h457

// ==========================================================================
// field positions
`define JIL_ADJ_DIR_BIT         6
`define JIL_PH_ADJ_BIT          5
`define JIL_DSCR_BIT            7
`define JIL_LID_MSB             4
`define JIL_K_MSB               4
`define JIL_CS_LSB              6

// ==========================================================================
// reset values
`define JIL_RST_DEV_IDENT       8'h00
`define JIL_RST_BANK_IDENT      8'h00
`define JIL_RST_LANE0_ADJ       7'h00
`define JIL_RST_DSCR            1'h1
`define JIL_RST_FRAMES_MF       5'h1f
`define JIL_RST_LANES_M1        5'h07
`define JIL_RST_OCTETS_M1       8'h00
`define JIL_RST_CONV_M1         8'h01
`define JIL_RST_CS              2'h0
`define JIL_RST_RES_M1          5'h0f

// ==========================================================================
// alignment sequence octet indices (lane configuration words)
`define JIL_IDX_W               4
`define JIL_IDX_LANE_ID         4'h2
`define JIL_IDX_LAST_FIELD      4'hc
`define JIL_IDX_CHECKSUM        4'hd

`endif

/* verification/jil_regs_sva.sv */
// Purpose: port assertions for the lane alignment register bank
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every jil_regs instance
`timescale 1ns/1ps
`default_nettype none
`include "jil_map.vh"

module jil_regs_sva (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // configuration port
    input wire logic [11:0] cfg_addr,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [7:0]  cfg_wdata,
    input wire logic [7:0]  cfg_rdata,
    input wire logic        cfg_rvalid,
    // lane 7 octets
    input wire logic        l7_ilas_start,
    input wire logic        l7_oct_vld,
    input wire logic [3:0]  l7_oct_idx,
    input wire logic [7:0]  l7_oct_data,
    // link core parameters
    input wire logic [7:0]  link_device_identifier,
    input wire logic [7:0]  link_bank_identifier,
    input wire logic [4:0]  lane_zero_identifier,
    input wire logic        multiframe_adjust_direction,
    input wire logic        phase_adjust_request,
    input wire logic        descramble_enable,
    input wire logic [4:0]  frames_per_multiframe
);
    // ====
    // helpers
    logic [7:0] lid_q;
    logic [7:0] cks_q;
    wire        rd_at = cfg_rd && !l7_oct_vld;

    always @(posedge clk) begin
        if (rst) begin
            lid_q <= 8'h00;
            cks_q <= 8'h00;
        end else if (l7_oct_vld && l7_oct_idx == 4'h2) begin
            lid_q <= {3'h0, l7_oct_data[4:0]};
        end else if (l7_oct_vld && l7_oct_idx == 4'hd) begin
            cks_q <= l7_oct_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ====
    // assertions
    a_read_answer: assert property (cfg_rd |=> cfg_rvalid) else $error("read not answered");
    a_reset_vals: assert property ($fell(rst) |-> descramble_enable && frames_per_multiframe == 5'h1f &&
        link_bank_identifier == 8'h00 && lane_zero_identifier == 5'h00) else $error("bad reset value");
    a_bank_write: assert property (cfg_wr && cfg_addr == 12'h451 |-> ##2
        link_bank_identifier == $past(cfg_wdata, 2)) else $error("bank id not applied");
    a_lane0_write: assert property (cfg_wr && cfg_addr == 12'h452 |-> ##2
        {multiframe_adjust_direction, phase_adjust_request, lane_zero_identifier} == $past(cfg_wdata[6:0], 2))
        else $error("lane zero fields not applied");
    a_lanes_read: assert property (cfg_rd && cfg_addr == 12'h453 |=> cfg_rdata[6:0] == 7'h07)
        else $error("lane count field wrong");
    a_conv_read: assert property (cfg_rd && cfg_addr == 12'h456 |=> cfg_rdata == 8'h01)
        else $error("converter count wrong");
    a_ctrl_read: assert property (cfg_rd && cfg_addr == 12'h457 |=> cfg_rdata[7:5] == 3'h0)
        else $error("control bits not zero");
    a_lid_capture: assert property (rd_at && cfg_addr == 12'h442 |=> cfg_rdata == lid_q)
        else $error("lane id capture wrong");
    a_cks_capture: assert property (rd_at && cfg_addr == 12'h445 |=> cfg_rdata == cks_q)
        else $error("checksum capture wrong");

    c_lane0_write: cover property (cfg_wr && cfg_addr == 12'h452);
    c_cks_octet: cover property (l7_oct_vld && l7_oct_idx == 4'hd);
    c_dscr_read: cover property (cfg_rd && cfg_addr == 12'h453);
endmodule

bind jil_regs jil_regs_sva chk_u (.clk(clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .l7_ilas_start(l7_ilas_start), .l7_oct_vld(l7_oct_vld), .l7_oct_idx(l7_oct_idx),
    .l7_oct_data(l7_oct_data), .link_device_identifier(link_device_identifier),
    .link_bank_identifier(link_bank_identifier), .lane_zero_identifier(lane_zero_identifier),
    .multiframe_adjust_direction(multiframe_adjust_direction), .phase_adjust_request(phase_adjust_request),
    .descramble_enable(descramble_enable), .frames_per_multiframe(frames_per_multiframe));
`default_nettype wire

/* verification/jil_tx_model.sv */
// Purpose: lane 7 transmitter sending the alignment configuration octets
// Assumes: one octet a cycle, or one every other cycle with gap high
// Notes:   idle lane shows inverted last values, held octet only in reset (zeros)
`timescale 1ns/1ps
`default_nettype none

module jil_tx_model (
    // clock and control
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         go,
    input  wire logic         gap,
    // octet contents
    input  wire logic [103:0] cfg,
    input  wire logic [7:0]   cks,
    // lane side
    output var  logic         start,
    output var  logic         vld,
    output var  logic [3:0]   idx,
    output var  logic [7:0]   data,
    output var  logic         busy
);
    // ====
    // sequencer
    logic [3:0] n;

    always @(posedge clk) begin
        start <= 1'b0;
        vld   <= 1'b0;
        idx   <= ~idx;
        data  <= ~data;
        if (rst) begin
            busy <= 1'b0;
            idx  <= 4'h0;
            data <= 8'h00;
        end else if (go && !busy) begin
            start <= 1'b1;
            busy  <= 1'b1;
            n     <= 4'h0;
        end else if (busy && !(gap && vld)) begin
            vld  <= 1'b1;
            idx  <= n;
            data <= (n == 4'hd) ? cks : cfg[n * 8 +: 8];
            n    <= n + 4'h1;
            busy <= (n != 4'hd);
        end
    end
endmodule
`default_nettype wire

/* verification/tb_jesd_ilas_link_param_regs.sv */
// Purpose: random and corner tests of the lane alignment register bank
// Assumes: 125 MHz clock, transmitter model on the lane 7 port
// Notes:   expectations come from a shadow of the bank and functions
`timescale 1ns/1ps
`default_nettype none

module tb_jesd_ilas_link_param_regs;
    // ====
    // signals
    logic         clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, go = 0, gap = 0;
    logic [11:0]  cfg_addr = 0, a;
    logic [7:0]   cfg_wdata = 0, cks = 0, sh [8], cfg_rdata, dev_id, bank_id;
    logic [127:0] cfg = 0;
    logic [31:0]  r;
    logic [4:0]   lane0_id, k;
    logic [3:0]   idx;
    logic [7:0]   dat;
    logic         st, vld, busy, adj, ph, dscr, rvalid;
    integer       seed = 49602, error_cnt = 0, cmp_count = 0, i, j;

    jil_regs dut_u (.clk(clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(rvalid), .l7_ilas_start(st),
        .l7_oct_vld(vld), .l7_oct_idx(idx), .l7_oct_data(dat), .link_device_identifier(dev_id),
        .link_bank_identifier(bank_id), .lane_zero_identifier(lane0_id), .multiframe_adjust_direction(adj),
        .phase_adjust_request(ph), .descramble_enable(dscr), .frames_per_multiframe(k));
    jil_tx_model tx_u (.clk(clk), .rst(rst), .go(go), .gap(gap), .cfg(cfg[103:0]), .cks(cks),
        .start(st), .vld(vld), .idx(idx), .data(dat), .busy(busy));

    initial forever #4 clk = ~clk;

    task chk(input string n, input [7:0] s, input [7:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input [11:0] ad, input [7:0] d); // link core taken as held in soft reset
        @(posedge clk);
        cfg_wr    <= 1;
        cfg_addr  <= ad;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 0;
    endtask
    task rd(input [11:0] ad, input [7:0] e);
        @(posedge clk);
        cfg_rd   <= 1;
        cfg_addr <= ad;
        @(posedge clk);
        cfg_rd <= 0;
        #1;
        chk("rvalid", {7'h0, rvalid}, 8'h01);
        chk($sformatf("reg %h", ad), cfg_rdata, e);
    endtask
    task finish_test;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // readback after a write: writable bits take data, the rest keep their fixed value
    function logic [7:0] exp_wr(input [11:0] ad, input [7:0] o, input [7:0] d);
        case (ad)
            12'h450, 12'h451: return d;
            12'h452: return d & 8'h7f;
            12'h453: return {d[7], 7'h07};
            12'h455: return {3'h0, d[4:0]};
            default: return o;
        endcase
    endfunction
    function logic [7:0] csum(input [103:0] c); // modulo 256 field sum, as software forms it
        logic [7:0] s, o;
        s = 0;
        for (int n = 0; n < 13; n++) begin
            o = c[n * 8 +: 8];
            case (n)
                1: s += o[7:4] + o[3:0];
                2: s += o[6] + o[5] + o[4:0];
                3, 10: s += o[7] + o[4:0];
                5: s += o[4:0];
                7: s += o[7:6] + o[4:0];
                8, 9: s += o[7:5] + o[4:0];
                default: s += o;
            endcase
        end
        return s;
    endfunction

    initial begin
        sh = '{8'h00, 8'h00, 8'h00, 8'h87, 8'h00, 8'h1f, 8'h01, 8'h0f};
        repeat (16) @(posedge clk);
        rst <= 0;
        for (i = 0; i < 8; i++) rd(12'h450 + i, sh[i]);
        for (i = 0; i < 4; i++) rd(12'h442 + i + 2 * (i > 0), 8'h00);
        wr(12'h442, 8'hff);
        rd(12'h442, 8'h00);
        for (i = 0; i < 60; i++) begin
            r = $random(seed);
            a = {9'h08a, r[2:0]};
            wr(a, r[15:8]);
            sh[a[2:0]] = exp_wr(a, sh[a[2:0]], r[15:8]);
            rd(a, sh[a[2:0]]);
        end
        wr(12'h453, 8'h00);
        sh[3] = 8'h07;
        repeat (2) @(posedge clk);
        #1;
        chk("descramble", {7'h0, dscr}, {7'h0, sh[3][7]});
        chk("bank", bank_id, sh[1]);
        chk("lane0", {1'b0, adj, ph, lane0_id}, sh[2]);
        chk("frames", {3'h0, k}, sh[5]);
        chk("dev", dev_id, sh[0]);
        for (i = 0; i < 4; i++) begin
            cfg = (i == 0) ? '1 : {$random(seed), $random(seed), $random(seed), $random(seed)};
            r = $random(seed);
            cks <= r[7:0];
            gap <= i[0];
            @(posedge clk);
            go <= 1;
            @(posedge clk);
            go <= 0;
            for (j = 0; j < 40 && (j < 2 || busy); j++) begin
                @(posedge clk);
                #1;
            end
            if (busy) begin
                error_cnt++;
                i = 4;
            end else begin
                rd(12'h442, {3'h0, cfg[20:16]});
                rd(12'h445, cks);
                rd(12'h446, csum(cfg[103:0]));
            end
        end
        finish_test;
    end
endmodule
`default_nettype wire
